// ===== act_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module act_fifo #(
	parameter int width = 17,
	parameter int depth = 32
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [width-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [width-1:0] out_data
);
	localparam int aw = $clog2(depth);
	logic [width-1:0] mem [depth];
	logic [aw:0] wr_ptr;
	logic [aw:0] rd_ptr;
	logic [aw:0] next_wr_ptr;
	logic [aw:0] next_rd_ptr;
	logic push;
	logic pop;

	always_comb begin
		in_ready = (wr_ptr - rd_ptr) != (aw + 1)'(depth);
		out_valid = wr_ptr != rd_ptr;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = wr_ptr + (aw + 1)'(push);
		next_rd_ptr = rd_ptr + (aw + 1)'(pop);
		out_data = mem[rd_ptr[aw-1:0]];
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	// storage has no reset, so it stays out of the reset process
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr[aw-1:0]] <= in_data;
		end
	end
endmodule : act_fifo

`default_nettype wire

// ===== act_host.sv
`timescale 1ns/1ps
`default_nettype none
module act_host (
	output logic external_shift_clock,
	output logic cascade_in,
	input wire logic serial_out
);
	logic [33:0] got;
	// cascade line is driven from time zero, never left floating
	initial {external_shift_clock, cascade_in} = 2'b00;
	// clock stands low between frames; an idle upstream line keeps toggling
	// pin edges sit a quarter nanosecond past the call, off the clock grid for a frame started on a clock edge, so none then meets a sampling edge
	task automatic frame(input int n, input logic [15:0] up);
		#0.25;
		for (int i = 0; i < n; i++) begin
			cascade_in = (i >= 16 && i < 32) ? up[31 - i] : ~cascade_in;
			#62.5;
			got = {got[32:0], serial_out};
			// one normally-low shift clock serves the whole chain
			external_shift_clock = 1'b1;
			#62.5;
			external_shift_clock = 1'b0;
		end
	endtask : frame
endmodule : act_host
`default_nettype wire

// ===== act_params.svh
`ifndef ACT_PARAMS_SVH
`define ACT_PARAMS_SVH

`define ACT_WORD_BITS 16
`define ACT_FIFO_DEPTH 32
`define ACT_RESULT_RESET 16'h0000
`define ACT_BIPOLAR_MAX 16'h7fff
`define ACT_BIPOLAR_MIN 16'h8000
`define ACT_OFFSET_BIN_FLIP 16'h8000
`define ACT_COUNT_RESET 5'h00
`define ACT_LAST_BIT 5'h0f

`endif

// ===== act_pkg.sv
`include "act_params.svh"

package act_pkg;
	typedef logic [15:0] act_word_t;

	typedef struct packed {
		logic bipolar;
		act_word_t code;
	} act_sample_t;

	typedef enum logic [1:0] {
		act_idle = 2'b00,
		act_shift = 2'b01,
		act_pass = 2'b11
	} act_state_t;
endpackage : act_pkg

// ===== act_readout.sv
`timescale 1ns/1ps
`default_nettype none
`include "act_params.svh"

// Contract
// R1: cascade input used only with external clock
// R2: upstream output wires to downstream cascade input
// R3: one null bit between chained words
// R4: receiver discards each null bit
// R5: delayed convert control avoids null bits
// R6: prefer read after conversion when cascading
// R7: mixed scheme shares clock, convert, busy
// R8: thirty-four clocks read two upstream devices
// R9: seventeen clocks read downstream during conversion
// R10: receiver gates clock, drops middle null
// R11: unused cascade input tied, never floating
// R12: sleep request powers down analog, reference
// R13: result held in register while asleep
// R14: allow recovery after leaving power-down
// R15: bipolar two's complement, carry at zero
// R16: bipolar extremes 7fff and 8000
// R17: after own bits, forward cascade input
module act_readout
	import act_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic external_shift_clock,
	input wire logic clock_source_select,
	input wire logic cascade_in,
	input wire logic sleep_request,
	input wire logic [1:0] unused_pad,
	input wire logic result_valid,
	output logic result_ready,
	input wire act_sample_t result_in,
	output logic serial_out,
	output logic analog_enable,
	output logic reference_enable,
	output logic busy_shift
);
	////////////////////////////////////////////////////////////////
	// pin synchronisers: first stage read only by second stage
	logic [1:0] sclk_meta;
	logic [1:0] sclk_sync;
	logic [1:0] ext_meta;
	logic [1:0] ext_sync;
	logic [1:0] cas_meta;
	logic [1:0] cas_sync;
	logic [1:0] slp_meta;
	logic [1:0] slp_sync;
	logic sclk_prev;
	logic sclk_rise;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sclk_meta <= 2'b00;
			sclk_sync <= 2'b00;
			ext_meta <= 2'b00;
			ext_sync <= 2'b00;
			cas_meta <= 2'b00;
			cas_sync <= 2'b00;
			slp_meta <= 2'b00;
			slp_sync <= 2'b00;
			sclk_prev <= 1'b0;
		end else begin
			sclk_meta <= {sclk_meta[0], external_shift_clock};
			sclk_sync <= {sclk_sync[0], sclk_meta[1]};
			ext_meta <= {ext_meta[0], clock_source_select};
			ext_sync <= {ext_sync[0], ext_meta[1]};
			cas_meta <= {cas_meta[0], cascade_in};
			cas_sync <= {cas_sync[0], cas_meta[1]};
			slp_meta <= {slp_meta[0], sleep_request};
			slp_sync <= {slp_sync[0], slp_meta[1]};
			sclk_prev <= sclk_sync[1];
		end
	end

	logic ext_mode;
	logic cascade_bit;
	logic asleep;

	always_comb begin
		ext_mode = ext_sync[1];
		cascade_bit = cas_sync[1];
		asleep = slp_sync[1];
		sclk_rise = sclk_sync[1] && !sclk_prev;
	end

	////////////////////////////////////////////////////////////////
	// conversion results queue ahead of the shifter
	logic fifo_valid;
	logic fifo_ready;
	act_sample_t fifo_data;
	logic unused_ok;

	always_comb begin
		unused_ok = ^unused_pad;
	end

	act_fifo #(
		.width($bits(act_sample_t)),
		.depth(`ACT_FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst(rst),
		.in_valid(result_valid),
		.in_ready(result_ready),
		.in_data(result_in),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready),
		.out_data(fifo_data)
	);

	// offset binary from the core becomes two's complement in bipolar
	function automatic act_word_t act_encode(input act_sample_t s);
		act_word_t w;
		w = s.code;
		if (s.bipolar) begin
			w = s.code ^ `ACT_OFFSET_BIN_FLIP; // [R15] [R16]
		end
		return w;
	endfunction : act_encode

	////////////////////////////////////////////////////////////////
	// output shifter
	act_state_t state;
	act_state_t next_state;
	act_word_t shreg;
	act_word_t next_shreg;
	logic [4:0] count;
	logic [4:0] next_count;
	logic sout;
	logic next_sout;

	always_comb begin
		next_state = state;
		next_shreg = shreg;
		next_count = count;
		next_sout = sout;
		fifo_ready = 1'b0;
		unique case (state)
			act_idle: begin
				// loading is fine while asleep: the digital result side keeps running
				if (fifo_valid) begin
					fifo_ready = 1'b1;
					next_shreg = act_encode(fifo_data);
					next_sout = next_shreg[15];
					next_count = `ACT_COUNT_RESET;
					next_state = act_shift;
				end
			end
			act_shift: begin
				// shifting continues while asleep so held bits stay readable
				if (sclk_rise) begin // [R13]
					next_shreg = {shreg[14:0], 1'b0};
					if (count == `ACT_LAST_BIT) begin
						// the last rise drives a zero rather than the cascade bit, giving the null slot
						next_sout = 1'b0; // [R3]
						next_state = ext_mode ? act_pass : act_idle; // [R1]
					end else begin
						next_sout = shreg[14];
					end
					next_count = count + 5'h01;
				end
			end
			act_pass: begin
				if (!ext_mode) begin
					next_state = act_idle; // [R1]
				end else if (fifo_valid) begin
					next_state = act_idle;
				end else if (sclk_rise) begin
					next_sout = cascade_bit; // [R17]
				end
			end
			default: begin
				next_state = act_idle;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= act_idle;
			shreg <= `ACT_RESULT_RESET;
			count <= `ACT_COUNT_RESET;
			sout <= 1'b0;
		end else begin
			state <= next_state;
			shreg <= next_shreg;
			count <= next_count;
			sout <= next_sout;
		end
	end

	////////////////////////////////////////////////////////////////
	// power control
	logic power_on;
	logic next_power_on;

	always_comb begin
		next_power_on = !asleep; // [R12]
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			power_on <= 1'b0;
		end else begin
			power_on <= next_power_on;
		end
	end

	always_comb begin
		serial_out = sout;
		analog_enable = power_on;
		reference_enable = power_on;
		busy_shift = (state == act_shift) || unused_ok & 1'b0;
	end
endmodule : act_readout

`default_nettype wire

// ===== act_readout_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module act_readout_monitor (
	input wire logic clock,
	input wire logic rst,
	input wire logic external_shift_clock,
	input wire logic sleep_request,
	input wire logic busy_shift,
	input wire logic serial_out,
	input wire logic analog_enable,
	input wire logic reference_enable
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// five low cycles outlast the edge detector, so no rise is still in flight
	sequence quiet_s;
		(busy_shift && !external_shift_clock)[*5];
	endsequence
	chk_en_pair: assert property (analog_enable == reference_enable) else $error("split");
	// four synchroniser stages plus the power flop: the pin is seen on enables five edges on
	chk_sleep_off: assert property (sleep_request[*5] |=> !analog_enable) else $error("on");
	chk_wake_on: assert property ((!sleep_request)[*5] |=> analog_enable) else $error("off");
	chk_wake_rst: assert property ($fell(rst) |-> !analog_enable) else $error("early");
	chk_hold_out: assert property (quiet_s |=> $stable(serial_out)) else $error("moved");
	chk_busy_hold: assert property (quiet_s |=> busy_shift) else $error("dropped");
	chk_null_bit: assert property ($fell(busy_shift) |-> ##[0:1] !serial_out) else $error("null");
	chk_load_busy: assert property ($rose(busy_shift) |=> busy_shift[*3]) else $error("short");
endmodule : act_readout_monitor
bind act_readout act_readout_monitor u_mon (.clock, .rst, .external_shift_clock,
	.sleep_request, .busy_shift, .serial_out, .analog_enable, .reference_enable);
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
`define chk_eq(n, e, s) begin samples_checked++; if ((s) !== (e)) begin n_errors++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module tb
	import act_pkg::*;
;
	logic clock = 1'b0, rst = 1'b1, ext_mode = 1'b1, sleep = 1'b0, valid = 1'b0;
	logic shclk, casc, sout, ready, aen, ren, busy, taken;
	act_sample_t smp = '0;
	int n_errors = 0, samples_checked = 0, i;
	logic [31:0] seed = 32'ha1df_8416;
	logic [15:0] tbl[4] = '{16'hffff, 16'h0000, 16'h8000, 16'h7fff};
	logic [15:0] exp_q[$], w;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic results;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results
	initial forever #2 clock = ~clock;
	act_readout u_dut (.clock, .rst, .external_shift_clock(shclk), .clock_source_select(ext_mode),
		.cascade_in(casc), .sleep_request(sleep), .unused_pad(2'b00), .result_valid(valid),
		.result_ready(ready), .result_in(smp), .serial_out(sout), .analog_enable(aen),
		.reference_enable(ren), .busy_shift(busy));
	act_host u_host (.external_shift_clock(shclk), .cascade_in(casc), .serial_out(sout));
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		valid <= 1'b1;
		// fill until refused; the first word goes straight to the shifter
		for (i = 0; i < 40; i++) begin
			seed = lfsr(seed);
			smp <= (i < 4) ? {1'b1, tbl[i]} : seed[16:0];
			// ready is read at the falling edge, where it has settled
			@(negedge clock);
			taken = ready;
			@(posedge clock);
			if (taken !== 1'b1) break;
			// model: a bipolar output word is the core code less half scale
			exp_q.push_back(smp.bipolar ? 16'(int'(smp.code) - 32768) : smp.code);
		end
		// every result is converted before the first read starts
		valid <= 1'b0;
		`chk_eq("taken", 33, exp_q.size())
		for (i = 0; exp_q.size() > 1; i++) begin
			@(posedge clock);
			// words read after waking were queued before sleep, so no recovery wait
			sleep <= (i >= 8 && i < 20);
			u_host.frame(16, 16'h0000);
			w = exp_q.pop_front();
			`chk_eq("word", w, u_host.got[15:0])
			if (i == 12) `chk_eq("asleep", 2'b00, {aen, ren})
		end
		// sampling stays simultaneous, so the null bit is expected in the stream
		u_host.frame(33, seed[31:16]);
		w = exp_q.pop_front();
		`chk_eq("chain", {w, 1'b0, seed[31:16]}, u_host.got[32:0])
		@(posedge clock);
		ext_mode <= 1'b0;
		valid <= 1'b1;
		smp <= {1'b0, seed[15:0]};
		@(posedge clock);
		valid <= 1'b0;
		u_host.frame(33, seed[31:16]);
		`chk_eq("internal", {seed[15:0], 17'h0_0000}, u_host.got[32:0])
		`chk_eq("awake", 2'b11, {aen, ren})
		results();
	end
endmodule : tb
`default_nettype wire
